//--- pkg/tick_map.svh
// Register offsets, field positions and reset values of the core tick timer
`ifndef TICK_MAP_SVH
`define TICK_MAP_SVH

// ==========================================
// Register offsets
`define TICK_CTRL_OFS 8'h10
`define TICK_RELOAD_OFS 8'h14
`define TICK_CURRENT_OFS 8'h18
`define TICK_IRQ_STATUS_OFS 8'h1C
`define TICK_IRQ_MASK_OFS 8'h20

// ==========================================
// Control and status fields
`define TICK_ENABLE_BIT 0
`define TICK_INT_EN_BIT 1
`define TICK_CLK_SRC_BIT 2
`define TICK_FLAG_BIT 16
`define TICK_CTRL_RESET 32'h00000004

// ==========================================
// Counter and event layout
`define TICK_CNT_WIDTH 24
`define TICK_CNT_RESET 24'h000000
`define TICK_RELOAD_RESET 24'h000000
`define TICK_EVT_COUNT 2
`define TICK_EVT_PEND 0
`define TICK_EVT_WRAP 1

`endif

//--- pkg/tick_pkg.sv
// State types of the core tick timer and its helpers
`include "tick_map.svh"

package tick_pkg;

    // ==========================================
    // Main timer state
    typedef struct packed {
        logic [`TICK_CNT_WIDTH-1:0] current;
        logic [`TICK_CNT_WIDTH-1:0] reload;
        logic enable;
        logic int_en;
        logic clk_src;
        logic flag;
        logic pend;
        logic [31:0] rdata;
    } tick_state_s;

    // ==========================================
    // Reference clock synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ref_sync_s;

    // ==========================================
    // Interrupt status and mask state
    typedef struct packed {
        logic [`TICK_EVT_COUNT-1:0] status;
        logic [`TICK_EVT_COUNT-1:0] mask;
    } irq_state_s;

endpackage : tick_pkg

//--- rtl/core_tick_timer.sv
// Core tick timer: 24-bit reloading down counter with register port
// Operation
// - 24-bit counter decrements while enabled
// - At zero, reload next edge, continue
// - Flag bit 16 set on 1-to-0
// - Flag cleared by ctrl read, current write
// - Zero reload keeps counter at zero
// - Bit 2 selects clock; fixed 1 without ref
// - Bit 1 gates tick exception pend
// - Current write never pends exception
// - Bit 0 enables repeated counting
// - Reload holds 24 bits, upper reserved
// - Any current write clears counter
// - Current read returns live counter
// - Current upper bits read zero
//
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "tick_map.svh"

module core_tick_timer
#(
    parameter bit HAS_EXT_CLK = 1'b1
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    // External reference clock pin
    input wire logic ext_ref_clk,
    // Tick exception and interrupt
    output logic tick_pend,
    output logic irq
);
    import tick_pkg::*;

    tick_pkg::tick_state_s st;
    tick_pkg::tick_state_s next_st;

    logic ref_edge;
    logic [`TICK_EVT_COUNT-1:0] evt_set;
    logic [`TICK_EVT_COUNT-1:0] irq_status;
    logic [`TICK_EVT_COUNT-1:0] irq_mask;
    logic ctrl_wr;
    logic ctrl_rd;
    logic reload_wr;
    logic cvr_wr;
    logic status_wr;
    logic mask_wr;
    logic count_tick;
    logic run;
    logic hit_zero;

    // ==========================================
    // Reference clock edges
    ref_edge_sync u_ref_sync
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .ref_pin(ext_ref_clk),
        .ref_edge(ref_edge)
    );

    // ==========================================
    // Address decode
    assign ctrl_wr = wr_en && (addr == `TICK_CTRL_OFS);
    assign ctrl_rd = rd_en && (addr == `TICK_CTRL_OFS);
    assign reload_wr = wr_en && (addr == `TICK_RELOAD_OFS);
    assign cvr_wr = wr_en && (addr == `TICK_CURRENT_OFS);
    assign status_wr = wr_en && (addr == `TICK_IRQ_STATUS_OFS);
    assign mask_wr = wr_en && (addr == `TICK_IRQ_MASK_OFS);

    // ==========================================
    // Count qualification
    // core clock or ref edge
    assign count_tick = st.clk_src ? 1'b1 : ref_edge;
    assign run = st.enable && count_tick;
    // a clearing write is no wrap
    assign hit_zero = run && !cvr_wr && (st.current == 24'h000001);

    // ==========================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.pend = 1'b0;
        next_st.rdata = 32'h00000000;

        if (ctrl_wr)
        begin
            next_st.enable = wdata[`TICK_ENABLE_BIT];
            next_st.int_en = wdata[`TICK_INT_EN_BIT];
            // bit stuck at 1 without reference
            next_st.clk_src = HAS_EXT_CLK ? wdata[`TICK_CLK_SRC_BIT] : 1'b1;
        end

        if (reload_wr)
            next_st.reload = wdata[`TICK_CNT_WIDTH-1:0];

        if (cvr_wr)
            next_st.current = `TICK_CNT_RESET;
        else if (run)
        begin
            // wrap to reload, zero stays zero
            if (st.current == `TICK_CNT_RESET)
                next_st.current = st.reload;
            else
                next_st.current = st.current - 24'h000001;
        end

        // cleared by read or current write
        if (ctrl_rd || cvr_wr)
            next_st.flag = 1'b0;
        if (hit_zero)
            next_st.flag = 1'b1;

        next_st.pend = hit_zero && st.int_en;

        if (rd_en)
        begin
            unique case (addr)
                `TICK_CTRL_OFS:
                begin
                    next_st.rdata[`TICK_ENABLE_BIT] = st.enable;
                    next_st.rdata[`TICK_INT_EN_BIT] = st.int_en;
                    next_st.rdata[`TICK_CLK_SRC_BIT] = st.clk_src;
                    next_st.rdata[`TICK_FLAG_BIT] = st.flag;
                end
                `TICK_RELOAD_OFS:
                    next_st.rdata[`TICK_CNT_WIDTH-1:0] = st.reload;
                `TICK_CURRENT_OFS:
                    next_st.rdata[`TICK_CNT_WIDTH-1:0] = st.current;
                `TICK_IRQ_STATUS_OFS:
                    next_st.rdata[`TICK_EVT_COUNT-1:0] = irq_status;
                `TICK_IRQ_MASK_OFS:
                    next_st.rdata[`TICK_EVT_COUNT-1:0] = irq_mask;
                // Unmapped reads answer zero
                default:
                    next_st.rdata = 32'h00000000;
            endcase
        end
    end

    // ==========================================
    // State register
    // Counter reset value is fixed; software still clears it first
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st.current <= `TICK_CNT_RESET;
            st.reload <= `TICK_RELOAD_RESET;
            st.enable <= 1'b0;
            st.int_en <= 1'b0;
            st.clk_src <= 1'b1;
            st.flag <= 1'b0;
            st.pend <= 1'b0;
            st.rdata <= 32'h00000000;
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign tick_pend = st.pend;

    // ==========================================
    // Interrupt events
    assign evt_set[`TICK_EVT_PEND] = hit_zero && st.int_en;
    assign evt_set[`TICK_EVT_WRAP] = hit_zero;

    tick_irq_ctrl u_irq
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .evt_set(evt_set),
        .status_wr(status_wr),
        .mask_wr(mask_wr),
        .wdata(wdata[`TICK_EVT_COUNT-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ==========================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    a_count_down: assert property (
        run && !wr_en && st.current != 24'h000000
        |=> st.current == $past(st.current) - 24'h000001)
        else $error("counter did not decrement");

    a_reload_wrap: assert property (
        run && !wr_en && st.current == 24'h000000
        |=> st.current == $past(st.reload))
        else $error("counter did not reload at zero");

    a_flag_set: assert property (
        run && !wr_en && st.current == 24'h000001
        |=> st.flag)
        else $error("flag not set on wrap");

    a_flag_read: assert property (
        ctrl_rd
        |=> rdata[`TICK_FLAG_BIT] == $past(st.flag))
        else $error("flag read back wrong");

    a_flag_clear: assert property (
        (ctrl_rd || cvr_wr) && !hit_zero
        |=> !st.flag)
        else $error("flag not cleared");

    a_zero_stays: assert property (
        st.enable && st.reload == 24'h000000 && st.current == 24'h000000 && !wr_en
        |=> st.current == 24'h000000 ##1 !tick_pend)
        else $error("zero reload moved");

    a_src_fixed: assert property (
        HAS_EXT_CLK || st.clk_src)
        else $error("clock source bit left core clock");

    a_pend_gate: assert property (
        hit_zero
        |=> tick_pend == $past(st.int_en))
        else $error("pend does not follow enable");

    a_pend_pulse: assert property (
        tick_pend
        |=> !tick_pend)
        else $error("pend longer than one cycle");

    a_write_nopend: assert property (
        cvr_wr
        |=> st.current == 24'h000000 && !tick_pend)
        else $error("current write pended or kept value");

    a_ctrl_enable: assert property (
        ctrl_wr
        |=> st.enable == $past(wdata[`TICK_ENABLE_BIT]))
        else $error("enable bit not taken");

    a_reload_low: assert property (
        reload_wr
        |=> st.reload == $past(wdata[`TICK_CNT_WIDTH-1:0]))
        else $error("reload value not taken");

    a_hold_off: assert property (
        !st.enable && !wr_en
        |=> $stable(st.current) && !$rose(st.flag) && !tick_pend)
        else $error("disabled counter moved");

    a_cvr_upper: assert property (
        rd_en && addr == `TICK_CURRENT_OFS
        |=> rdata[31:24] == 8'h00 && rdata[23:0] == $past(st.current))
        else $error("current read wrong");

    a_ext_hold: assert property (
        st.enable && !st.clk_src && !ref_edge && !wr_en
        |=> $stable(st.current))
        else $error("counter moved without reference edge");

    // Read data only after a strobe
    a_rdata_idle: assert property (
        !rd_en
        |=> rdata == 32'h00000000)
        else $error("read data outside read cycle");

    // Main scenarios
    c_tick_pend: cover property (tick_pend);
    c_ext_count: cover property (!st.clk_src && run ##1 run);
    c_zero_reload: cover property (st.enable && st.reload == 24'h000000 && st.current == 24'h000000);
    c_irq: cover property (irq);
    c_cvr_clash: cover property (cvr_wr && run && st.current == 24'h000001);

endmodule : core_tick_timer

//--- rtl/ref_edge_sync.sv
// Synchroniser and rising edge detector for the external reference clock
`timescale 1ns/100ps

module ref_edge_sync
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Pin and edge pulse
    input wire logic ref_pin,
    output logic ref_edge
);
    import tick_pkg::*;

    tick_pkg::ref_sync_s st;
    tick_pkg::ref_sync_s next_st;

    // ==========================================
    // Two flops before any logic, third for the edge
    always_comb
    begin
        next_st.s1 = ref_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign ref_edge = st.s2 & ~st.s3;

    // ==========================================
    // Checks
    // edge pulse single cycle
    a_edge_single: assert property (@(posedge ref_clk) disable iff (!resetn)
        ref_edge |=> !ref_edge) else $error("reference edge pulse longer than one cycle");

endmodule : ref_edge_sync

//--- rtl/tick_irq_ctrl.sv
// Sticky event status, mask and level interrupt of the core tick timer
`timescale 1ns/100ps
`include "tick_map.svh"

module tick_irq_ctrl
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Events and register writes
    input wire logic [`TICK_EVT_COUNT-1:0] evt_set,
    input wire logic status_wr,
    input wire logic mask_wr,
    input wire logic [`TICK_EVT_COUNT-1:0] wdata,
    // State and interrupt
    output logic [`TICK_EVT_COUNT-1:0] status,
    output logic [`TICK_EVT_COUNT-1:0] mask,
    output logic irq
);
    import tick_pkg::*;

    tick_pkg::irq_state_s st;
    tick_pkg::irq_state_s next_st;

    // ==========================================
    // Set wins over a write-one clear
    always_comb
    begin
        next_st = st;
        if (status_wr)
            next_st.status = st.status & ~wdata;
        next_st.status = next_st.status | evt_set;
        if (mask_wr)
            next_st.mask = wdata;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign status = st.status;
    assign mask = st.mask;
    assign irq = |(st.status & st.mask);

    // ==========================================
    // Checks
    a_set_wins: assert property (@(posedge ref_clk) disable iff (!resetn)
        evt_set[0] |=> status[0]) else $error("event lost against clear");
    a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
        mask_wr && !(|(wdata & status)) && !(|evt_set) |=> !irq) else $error("masked interrupt still high");

endmodule : tick_irq_ctrl

//--- tb/tb.sv
// Self-checking bench of the core tick timer
`timescale 1ns/100ps
`include "tick_map.svh"

module tb;

    // ==========================================
    // Signals
    logic ref_clk;
    logic resetn;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [31:0] rdata;
    logic ext_ref_clk;
    logic tick_pend;
    logic irq;
    int errors;
    int cmp_count;
    int pend_cnt;
    int p0;
    int n;
    logic [31:0] va;
    logic [31:0] vb;

    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    row_s rows [7];

    core_tick_timer #(.HAS_EXT_CLK(1'b1)) core_tick_timer_inst (.ref_clk(ref_clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .ext_ref_clk(ext_ref_clk), .tick_pend(tick_pend), .irq(irq));

    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Pulses counted on the edge, so a stuck-high pend shows as extra counts
    always @(posedge ref_clk)
        if (tick_pend === 1'b1)
            pend_cnt <= pend_cnt + 1;

    // ==========================================
    // Tasks
    task automatic results;
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(v, e);
    endtask : rc

    task automatic wait_pend(output int k);
        k = 0;
        repeat (50)
        begin
            @(posedge ref_clk);
            #1;
            k++;
            if (tick_pend === 1'b1)
                return;
        end
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        results();
    endtask : wait_pend

    // ==========================================
    // Main sequence
    initial
    begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ext_ref_clk = 1'b0;
        errors = 0;
        cmp_count = 0;
        pend_cnt = 0;
        rows = '{'{`TICK_RELOAD_OFS, 32'hFFFFFFFF, 32'h00FFFFFF}, '{`TICK_RELOAD_OFS, 32'h12345678, 32'h00345678},
            '{`TICK_CURRENT_OFS, 32'hFFFFFFFF, 32'h0}, '{`TICK_IRQ_MASK_OFS, 32'hFFFFFFFF, 32'h3},
            '{`TICK_IRQ_MASK_OFS, 32'h0, 32'h0}, '{8'h04, 32'hFFFFFFFF, 32'h0}, '{`TICK_CTRL_OFS, 32'h0, 32'h0}};
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, va);
            chk(va, rows[i].e);
        end
        // Second reset in mid-run restores the register reset values
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({30'h0, tick_pend, irq}, 32'h0);
        @(posedge ref_clk);
        resetn <= 1'b1;
        rc(`TICK_CTRL_OFS, 32'h4);
        rc(`TICK_RELOAD_OFS, 32'h0);
        rc(`TICK_CURRENT_OFS, 32'h0);
        rc(`TICK_IRQ_STATUS_OFS, 32'h0);
        // Core clock counting, reload 3 gives a four-cycle period
        wr(`TICK_RELOAD_OFS, 32'h3);
        wr(`TICK_CURRENT_OFS, 32'h0);
        wr(`TICK_CTRL_OFS, 32'h7);
        wait_pend(n);
        wait_pend(n);
        chk(n, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(`TICK_CTRL_OFS, 32'h4);
        rd(`TICK_CURRENT_OFS, va);
        p0 = pend_cnt;
        repeat (5) @(posedge ref_clk);
        rd(`TICK_CURRENT_OFS, vb);
        chk(vb, va);
        chk(pend_cnt - p0, 32'h0);
        rc(`TICK_CTRL_OFS, 32'h00010004);
        rc(`TICK_CTRL_OFS, 32'h4);
        rc(`TICK_IRQ_STATUS_OFS, 32'h3);
        // Level interrupt follows status and mask
        wr(`TICK_IRQ_MASK_OFS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`TICK_IRQ_STATUS_OFS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rc(`TICK_IRQ_STATUS_OFS, 32'h2);
        wr(`TICK_IRQ_STATUS_OFS, 32'h2);
        // Interrupt enable off: wraps counted, nothing pended
        p0 = pend_cnt;
        wr(`TICK_CTRL_OFS, 32'h5);
        repeat (20) @(posedge ref_clk);
        wr(`TICK_CTRL_OFS, 32'h4);
        chk(pend_cnt - p0, 32'h0);
        rc(`TICK_IRQ_STATUS_OFS, 32'h2);
        wr(`TICK_CURRENT_OFS, 32'h00ABCDEF);
        rc(`TICK_CTRL_OFS, 32'h4);
        // Zero reload parks the counter
        wr(`TICK_RELOAD_OFS, 32'h0);
        p0 = pend_cnt;
        wr(`TICK_CTRL_OFS, 32'h7);
        repeat (10) @(posedge ref_clk);
        rc(`TICK_CURRENT_OFS, 32'h0);
        chk(pend_cnt - p0, 32'h0);
        // Running write to current never pends, reads are live
        wr(`TICK_RELOAD_OFS, 32'h100);
        repeat (5) @(posedge ref_clk);
        p0 = pend_cnt;
        wr(`TICK_CURRENT_OFS, 32'h1);
        rd(`TICK_CURRENT_OFS, va);
        rd(`TICK_CURRENT_OFS, vb);
        chk(va - vb, 32'h2);
        repeat (20) @(posedge ref_clk);
        chk(pend_cnt - p0, 32'h0);
        // Current write in the cycle of a 1-to-0 step swallows the pend
        wr(`TICK_RELOAD_OFS, 32'h3);
        wr(`TICK_CURRENT_OFS, 32'h0);
        wait_pend(n);
        repeat (2) @(posedge ref_clk);
        p0 = pend_cnt;
        wr(`TICK_CURRENT_OFS, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk(pend_cnt - p0, 32'h0);
        // External reference: nine slow edges, reload 2, three pends
        wr(`TICK_CTRL_OFS, 32'h0);
        wr(`TICK_RELOAD_OFS, 32'h2);
        wr(`TICK_CURRENT_OFS, 32'h0);
        wr(`TICK_CTRL_OFS, 32'h3);
        rc(`TICK_CTRL_OFS, 32'h3);
        p0 = pend_cnt;
        repeat (9)
        begin
            ext_ref_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_ref_clk <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        chk(pend_cnt - p0, 32'h3);
        results();
    end

endmodule : tb
